// File: rtl/spo_pulse_out.sv
// Single-phase pulse train generator, 20 Hz to 2 kHz, on one of two output bits.
// Assumes a 10 MHz clock and a register port whose read data stands in the cycle after the read strobe.
//
// Function
// - Square train from 20 Hz to 2 kHz.
// - Select 000 drives bit a, 010 bit b.
// - Mode 000 counted, 001 continuous, latched at start.
// - Frequency is four-digit BCD, codes 0002 to 0200.
// - Counted mode halts after preset 1..16777215 pulses.
// - Never drive both output bits together.
// - Count captured at start, later loads ignored.
// - Reissued speed command retunes without stopping.
// - Continuous mode runs until a stop.
// - Speed command with frequency zero stops output.
// - Mode control port 000 code 003 stops.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "spo_consts.svh"

module spo_pulse_out (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input wire logic [`SPO_ADDR_W-1:0] addr,
    input wire logic [`SPO_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`SPO_DATA_W-1:0] rdata,
    // Pulse outputs to the motor driver.
    output logic pulse_out_bit_a,
    output logic pulse_out_bit_b
);

    function automatic logic bcd_ok(input logic [15:0] v);
        bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
    endfunction

    function automatic logic [13:0] bcd_val(input logic [15:0] v);
        bcd_val = 14'(v[15:12] * 14'd1000 + v[11:8] * 14'd100 + v[7:4] * 14'd10 + 14'(v[3:0]));
    endfunction

    spo_pkg::spo_state_t state_q;
    logic [11:0] sel_pin_q;
    logic [11:0] sel_mode_q;
    logic [15:0] cnt_lo_q;
    logic [15:0] cnt_hi_q;
    logic [23:0] preset_q;
    logic preset_ok_q;
    logic pin_b_q;
    logic mode_cont_q;
    logic [11:0] freq_hz_q;
    logic [23:0] acc_q;
    logic level_q;
    logic [23:0] remain_q;
    logic done_q;
    logic out_a_q;
    logic out_b_q;
    logic [`SPO_DATA_W-1:0] rdata_q;
    logic [17:0] since_toggle_q;

    logic running;
    logic wr_speed;
    logic wr_cnt_set;
    logic wr_ctrl;
    logic [13:0] f_code;
    logic f_ok;
    logic f_zero;
    logic sel_ok;
    logic sel_match;
    logic start;
    logic retune;
    logic stop_zero;
    logic stop_ctrl;
    logic [23:0] acc_sum;
    logic toggle;
    logic pulse_end;
    logic last_pulse;
    logic [26:0] cnt_val;
    logic cnt_ok;

    assign running = (state_q == spo_pkg::SPO_RUN);
    assign wr_speed = wr && (addr == `SPO_REG_SPEED);
    assign wr_cnt_set = wr && (addr == `SPO_REG_CNT_SET);
    assign wr_ctrl = wr && (addr == `SPO_REG_MODE_CTRL);
    assign f_code = bcd_val(wdata[15:0]);
    assign f_zero = (wdata[15:0] == 16'h0000);
    assign f_ok = bcd_ok(wdata[15:0]) && (f_code >= `SPO_FREQ_MIN_CODE) && (f_code <= `SPO_FREQ_MAX_CODE);
    assign sel_ok = ((sel_pin_q == `SPO_PIN_A) || (sel_pin_q == `SPO_PIN_B))
        && ((sel_mode_q == `SPO_MODE_COUNTED) || (sel_mode_q == `SPO_MODE_CONT));
    assign sel_match = (pin_b_q == (sel_pin_q == `SPO_PIN_B)) && (mode_cont_q == (sel_mode_q == `SPO_MODE_CONT));
    // A counted start with no loaded count is refused.
    assign start = wr_speed && !running && sel_ok && f_ok
        && ((sel_mode_q == `SPO_MODE_CONT) || preset_ok_q);
    assign retune = wr_speed && running && sel_ok && sel_match && f_ok;
    assign stop_zero = wr_speed && running && sel_ok && sel_match && f_zero;
    assign stop_ctrl = wr_ctrl && (wdata[27:16] == `SPO_CTRL_PORT) && (wdata[11:0] == `SPO_CTRL_STOP);
    // Phase accumulator toggles the level at twice the output rate, so the average period is exact.
    assign acc_sum = acc_q + 24'(freq_hz_q);
    assign toggle = running && (acc_sum >= `SPO_TOGGLE_LIMIT);
    assign pulse_end = toggle && level_q;
    assign last_pulse = pulse_end && !mode_cont_q && (remain_q == 24'h000001);
    assign cnt_val = 27'(bcd_val(cnt_hi_q)) * 27'd10000 + 27'(bcd_val(cnt_lo_q));
    assign cnt_ok = bcd_ok(cnt_lo_q) && bcd_ok(cnt_hi_q) && (cnt_val != 27'd0) && (cnt_val <= `SPO_COUNT_MAX);

    // Operand registers written by software.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_pin_q <= 12'h000;
            sel_mode_q <= 12'h000;
            cnt_lo_q <= 16'h0000;
            cnt_hi_q <= 16'h0000;
        end else if (wr) begin
            if (addr == `SPO_REG_SEL) begin
                sel_pin_q <= wdata[11:0];
                sel_mode_q <= wdata[27:16];
            end
            if (addr == `SPO_REG_CNT_LO) begin
                cnt_lo_q <= wdata[15:0];
            end
            if (addr == `SPO_REG_CNT_HI) begin
                cnt_hi_q <= wdata[15:0];
            end
        end
    end

    // Count preset; the active count is separate, so a load during a run has no effect on it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preset_q <= 24'h000000;
            preset_ok_q <= 1'b0;
        end else if (wr_cnt_set && cnt_ok) begin
            preset_q <= 24'(cnt_val);
            preset_ok_q <= 1'b1;
        end
    end

    // Run control.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= spo_pkg::SPO_IDLE;
            pin_b_q <= 1'b0;
            mode_cont_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            case (state_q)
                spo_pkg::SPO_IDLE: begin
                    if (start) begin
                        state_q <= spo_pkg::SPO_RUN;
                        pin_b_q <= (sel_pin_q == `SPO_PIN_B);
                        mode_cont_q <= (sel_mode_q == `SPO_MODE_CONT);
                        done_q <= 1'b0;
                    end
                end
                spo_pkg::SPO_RUN: begin
                    if (stop_zero || stop_ctrl) begin
                        state_q <= spo_pkg::SPO_IDLE;
                    end else if (last_pulse) begin
                        state_q <= spo_pkg::SPO_IDLE;
                        done_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= spo_pkg::SPO_IDLE;
                end
            endcase
        end
    end

    // Frequency, latched at start and replaced on a retune.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            freq_hz_q <= 12'h000;
        end else if (start || retune) begin
            freq_hz_q <= 12'(f_code) * `SPO_HZ_PER_CODE;
        end
    end

    // Waveform: starts high, toggles on accumulator wrap.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= 24'h000000;
            level_q <= 1'b0;
        end else if (start) begin
            acc_q <= 24'h000000;
            level_q <= 1'b1;
        end else if (!running || stop_zero || stop_ctrl || last_pulse) begin
            acc_q <= 24'h000000;
            level_q <= 1'b0;
        end else if (toggle) begin
            acc_q <= acc_sum - `SPO_TOGGLE_LIMIT;
            level_q <= !level_q;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // Pulses left in counted mode, counted at each falling edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remain_q <= 24'h000000;
        end else if (start) begin
            remain_q <= preset_q;
        end else if (pulse_end && !mode_cont_q) begin
            remain_q <= remain_q - 24'h000001;
        end
    end

    // Cycles since the last level change, used only by the half-period checks below.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since_toggle_q <= 18'h00000;
        end else if (start || toggle || !running) begin
            since_toggle_q <= 18'h00000;
        end else begin
            since_toggle_q <= since_toggle_q + 18'h00001;
        end
    end

    // Only the selected bit follows the level; the other stays low.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            out_a_q <= running && !pin_b_q && level_q;
            out_b_q <= running && pin_b_q && level_q;
        end
    end

    // Read data stands in the cycle after the strobe and is zero otherwise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `SPO_REG_SEL: rdata_q <= {4'h0, sel_mode_q, 4'h0, sel_pin_q};
                `SPO_REG_SPEED: rdata_q <= {20'h00000, freq_hz_q};
                `SPO_REG_CNT_LO: rdata_q <= {16'h0000, cnt_lo_q};
                `SPO_REG_CNT_HI: rdata_q <= {16'h0000, cnt_hi_q};
                `SPO_REG_STATUS: rdata_q <= {27'h0000000, pin_b_q, mode_cont_q, running, done_q, preset_ok_q};
                `SPO_REG_PV: rdata_q <= {8'h00, remain_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign rdata = rdata_q;
    assign pulse_out_bit_a = out_a_q;
    assign pulse_out_bit_b = out_b_q;

    AST_ONE_BIT: assert property (@(posedge clk) disable iff (!nrst) !(out_a_q && out_b_q))
        else $error("Both pulse outputs high.");
    AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
        (out_a_q |-> !pin_b_q) and (out_b_q |-> pin_b_q))
        else $error("Pulse on unselected bit.");
    AST_FREQ_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        running |-> (freq_hz_q >= 12'd20) && (freq_hz_q <= 12'd2000))
        else $error("Running frequency out of range.");
    AST_FREQ_SCALE: assert property (@(posedge clk) disable iff (!nrst)
        (start || retune) |=> freq_hz_q == 12'($past(f_code)) * 12'd10)
        else $error("Frequency not ten times the code.");
    AST_MODE_LATCH: assert property (@(posedge clk) disable iff (!nrst)
        start |=> running && (mode_cont_q == $past(sel_mode_q == `SPO_MODE_CONT)))
        else $error("Mode not latched at start.");
    AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        (running && wr_cnt_set && !pulse_end && !start) |=> $stable(remain_q))
        else $error("Count load changed the active count.");
    AST_AUTO_STOP: assert property (@(posedge clk) disable iff (!nrst)
        last_pulse |=> !running && done_q ##1 !out_a_q && !out_b_q)
        else $error("Counted run did not halt.");
    AST_ZERO_STOP: assert property (@(posedge clk) disable iff (!nrst)
        stop_zero |=> !running ##1 !out_a_q && !out_b_q)
        else $error("Zero frequency did not stop.");
    AST_CTRL_STOP: assert property (@(posedge clk) disable iff (!nrst)
        (running && stop_ctrl) |=> !running)
        else $error("Stop control ignored.");
    AST_CONT_RUN: assert property (@(posedge clk) disable iff (!nrst)
        (running && mode_cont_q && !stop_zero && !stop_ctrl) |=> running)
        else $error("Continuous run ended without stop.");
    AST_RETUNE: assert property (@(posedge clk) disable iff (!nrst)
        retune |=> running && $stable(pin_b_q))
        else $error("Retune interrupted the run.");

    // Waveform timing: every half period lies between the 2 kHz and the 20 Hz bound.
    AST_START_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        start |=> running && level_q)
        else $error("Run did not start with a high half.");
    AST_PIN_FOLLOW: assert property (@(posedge clk) disable iff (!nrst)
        running |=> ((out_a_q || out_b_q) == $past(level_q)))
        else $error("Output bit does not follow the level.");
    AST_HALF_MIN: assert property (@(posedge clk) disable iff (!nrst)
        toggle |-> (since_toggle_q >= `SPO_HALF_MIN_CYC))
        else $error("Half period shorter than at 2 kHz.");
    AST_HALF_MAX: assert property (@(posedge clk) disable iff (!nrst)
        running |-> (since_toggle_q < `SPO_HALF_MAX_CYC))
        else $error("Half period longer than at 20 Hz.");
    AST_FREQ_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        (running && !retune) |=> $stable(freq_hz_q))
        else $error("Frequency changed without a speed command.");

    // Routing and idle level of the two output bits.
    AST_UNSEL_LOW: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_b_q |=> !out_b_q) and (pin_b_q |=> !out_a_q))
        else $error("Unselected bit not held low.");
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
        !running |=> !out_a_q && !out_b_q)
        else $error("Output bit high while stopped.");

    // Command acceptance and count handling.
    AST_SPEED_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
        (wr_speed && !running && !f_ok) |=> !running)
        else $error("Out of range frequency started a run.");
    AST_CTRL_OTHER: assert property (@(posedge clk) disable iff (!nrst)
        (running && wr_ctrl && !stop_ctrl && !last_pulse) |=> running)
        else $error("Mode control for another port stopped the run.");
    AST_COUNTED_PRESET: assert property (@(posedge clk) disable iff (!nrst)
        (start && (sel_mode_q == `SPO_MODE_COUNTED)) |-> preset_ok_q && (preset_q != 24'h000000))
        else $error("Counted run started without a count.");
    AST_START_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        start |=> remain_q == $past(preset_q))
        else $error("Count not captured at start.");
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!nrst)
        (pulse_end && !mode_cont_q) |=> remain_q == $past(remain_q) - 24'h000001)
        else $error("Pulse count did not step down.");
    AST_PV_EMPTY: assert property (@(posedge clk) disable iff (!nrst)
        last_pulse |=> remain_q == 24'h000000)
        else $error("Pulses left after a counted run.");
    AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        start |=> !done_q)
        else $error("Done flag not cleared by start.");

    CVR_COUNTED_DONE: cover property (@(posedge clk) disable iff (!nrst) last_pulse);
    CVR_RETUNE: cover property (@(posedge clk) disable iff (!nrst) retune);
    CVR_BIT_B: cover property (@(posedge clk) disable iff (!nrst) out_b_q);
    CVR_CTRL_STOP: cover property (@(posedge clk) disable iff (!nrst) running && stop_ctrl);
    CVR_ZERO_STOP: cover property (@(posedge clk) disable iff (!nrst) stop_zero);

endmodule

// File: rtl/spo_consts.svh
// Constants of the single-phase pulse output: register offsets, operand codes and timing.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef SPO_CONSTS_SVH
`define SPO_CONSTS_SVH

`define SPO_ADDR_W 8
`define SPO_DATA_W 32
`define SPO_REG_SEL 8'h00
`define SPO_REG_SPEED 8'h04
`define SPO_REG_CNT_LO 8'h08
`define SPO_REG_CNT_HI 8'h0C
`define SPO_REG_CNT_SET 8'h10
`define SPO_REG_MODE_CTRL 8'h14
`define SPO_REG_STATUS 8'h18
`define SPO_REG_PV 8'h1C

`define SPO_PIN_A 12'h000
`define SPO_PIN_B 12'h010
`define SPO_MODE_COUNTED 12'h000
`define SPO_MODE_CONT 12'h001
`define SPO_CTRL_STOP 12'h003
`define SPO_CTRL_PORT 12'h000

`define SPO_FREQ_MIN_CODE 14'd2
`define SPO_FREQ_MAX_CODE 14'd200
`define SPO_HZ_PER_CODE 12'd10
`define SPO_COUNT_MAX 27'd16777215
`define SPO_CLK_HZ 24'd10000000
`define SPO_TOGGLE_LIMIT 24'(`SPO_CLK_HZ / 24'd2)
`define SPO_HALF_MIN_CYC 18'd2499
`define SPO_HALF_MAX_CYC 18'd250000

`endif

// File: rtl/spo_pkg.sv
// Types of the single-phase pulse output.
// Assumes spo_consts.svh is on the include path.
package spo_pkg;
    typedef enum logic [1:0] {
        SPO_IDLE,
        SPO_RUN
    } spo_state_t;
endpackage

// File: dv/spo_motor_drv.sv
// Behavioural motor driver pulse input: counts pulses on each bit and times the last high half.
// Assumes the pulse bits are registered outputs of the generator on the same clock.
`timescale 1ns/1ps

module spo_motor_drv (
    // Clock, reset and count clear.
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    // Pulse and direction inputs.
    input wire logic pulse_out_bit_a,
    input wire logic pulse_out_bit_b,
    input wire logic rotation_direction,
    // Observations.
    output logic [31:0] cnt_a,
    output logic [31:0] cnt_b,
    output logic [31:0] hi_len,
    output logic both_seen,
    output logic dir_seen
);
    logic pa_q;
    logic pb_q;
    logic [31:0] run_q;

    // A pulse is counted when its high half ends.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst || clr) begin
            cnt_a <= 32'h0;
            cnt_b <= 32'h0;
            hi_len <= 32'h0;
            run_q <= 32'h0;
            both_seen <= 1'b0;
            dir_seen <= 1'b0;
            pa_q <= 1'b0;
            pb_q <= 1'b0;
        end else begin
            pa_q <= pulse_out_bit_a;
            pb_q <= pulse_out_bit_b;
            run_q <= (pulse_out_bit_a || pulse_out_bit_b) ? run_q + 32'h1 : 32'h0;
            if (pulse_out_bit_a && pulse_out_bit_b) begin
                both_seen <= 1'b1;
            end
            if (pa_q && !pulse_out_bit_a) begin
                cnt_a <= cnt_a + 32'h1;
            end
            if (pb_q && !pulse_out_bit_b) begin
                cnt_b <= cnt_b + 32'h1;
            end
            if ((pa_q || pb_q) && !(pulse_out_bit_a || pulse_out_bit_b)) begin
                hi_len <= run_q;
                dir_seen <= rotation_direction;
            end
        end
    end
endmodule

// File: dv/spo_pulse_out_tb_top.sv
// Testbench of the single-phase pulse output: register tasks, motor driver model, run checks.
// Assumes spo_consts.svh on the include path and a 10 MHz clock.
`timescale 1ns/1ps
`include "spo_consts.svh"

module spo_pulse_out_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic dir = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [31:0] ca;
    logic [31:0] cb;
    logic [31:0] hl;
    logic [31:0] t;
    logic pa;
    logic pb;
    logic both;
    logic dseen;
    int n_errors = 0;
    int comparisons = 0;

    always #50 clk = ~clk;

    spo_pulse_out i_spo_pulse_out (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pulse_out_bit_a(pa), .pulse_out_bit_b(pb));
    spo_motor_drv i_spo_motor_drv (.clk(clk), .nrst(nrst), .clr(clr), .pulse_out_bit_a(pa),
        .pulse_out_bit_b(pb), .rotation_direction(dir), .cnt_a(ca), .cnt_b(cb), .hi_len(hl), .both_seen(both),
        .dir_seen(dseen));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        if (name != "") chk(name, e, v & m);
    endtask

    task automatic wait_cnt(input bit use_b, input logic [31:0] n);
        for (int i = 0; i < 30000; i++) begin
            @(posedge clk);
            if ((use_b ? cb : ca) >= n) break;
        end
    endtask

    // Checks the last high half against half a period of f_hz, allowing one cycle of jitter.
    task automatic chk_half(input string name, input int f_hz);
        chk(name, 32'h1, {31'h0, (hl + 32'd1 >= 32'(5000000 / f_hz)) && (hl <= 32'(5000000 / f_hz) + 32'd1)});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        $display("wrong value watchdog expected end seen hang");
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        wr_reg(8'h20, 32'hFFFFFFFF);
        rd_chk(`SPO_REG_STATUS, 32'hFFFFFFFF, 32'h0, "status after reset");
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped read");
        wr_reg(`SPO_REG_SEL, 32'h00010000);
        wr_reg(`SPO_REG_SPEED, 32'h0201);
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h0, "run after code 0201");
        wr_reg(`SPO_REG_SEL, 32'h0);
        wr_reg(`SPO_REG_SPEED, 32'h0200);
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h0, "counted run without count");
        // Counted run of three pulses on bit a; a later load must not shorten or stretch it.
        wr_reg(`SPO_REG_CNT_LO, 32'h0003);
        wr_reg(`SPO_REG_CNT_HI, 32'h0000);
        wr_reg(`SPO_REG_CNT_SET, 32'h0);
        rd_chk(`SPO_REG_STATUS, 32'h1, 32'h1, "count loaded flag");
        wr_reg(`SPO_REG_SPEED, 32'h0200);
        wr_reg(`SPO_REG_CNT_LO, 32'h0005);
        wr_reg(`SPO_REG_CNT_SET, 32'h0);
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h4, "counted run started");
        for (int i = 0; i < 12000; i++) begin
            rd_chk(`SPO_REG_STATUS, 32'h0, 32'h0, "");
            if (v[2] === 1'b0) break;
        end
        // The last fall reaches the model two edges after the run flag drops.
        repeat (3) @(posedge clk);
        chk("pulses on bit a", 32'd3, ca);
        chk("pulses on bit b", 32'd0, cb);
        chk_half("high half at 2 kHz", 2000);
        rd_chk(`SPO_REG_STATUS, 32'h6, 32'h2, "counted done flags");
        rd_chk(`SPO_REG_PV, 32'h00FFFFFF, 32'h0, "pulses left");
        // Continuous run on bit b, retuned on the fly, then stopped by frequency zero; model counts start at zero.
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        dir <= 1'b1;
        wr_reg(`SPO_REG_SEL, 32'h00010010);
        wr_reg(`SPO_REG_SPEED, 32'h0100);
        wait_cnt(1'b1, 32'd1);
        chk_half("high half at 1 kHz", 1000);
        rd_chk(`SPO_REG_SPEED, 32'hFFF, 32'd1000, "frequency 1 kHz");
        wr_reg(`SPO_REG_SPEED, 32'h0200);
        t = cb + 32'd2;
        wait_cnt(1'b1, t);
        chk_half("high half after retune", 2000);
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h4, "running after retune");
        chk("pulses on bit a in b run", 32'd0, ca);
        chk("direction at last pulse", 32'h1, {31'h0, dseen});
        wr_reg(`SPO_REG_SPEED, 32'h0000);
        repeat (3) @(posedge clk);
        t = cb;
        chk("bit b after zero speed", 32'h0, {31'h0, pb});
        repeat (6000) @(posedge clk);
        chk("pulses after zero speed", t, cb);
        // Continuous run on bit a, stopped by mode control; another port must be ignored.
        wr_reg(`SPO_REG_SEL, 32'h00010000);
        wr_reg(`SPO_REG_SPEED, 32'h0200);
        wait_cnt(1'b0, 32'd1);
        wr_reg(`SPO_REG_MODE_CTRL, 32'h00010003);
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h4, "run after other port stop");
        wr_reg(`SPO_REG_MODE_CTRL, 32'h00000003);
        repeat (3) @(posedge clk);
        chk("bit a after stop", 32'h0, {31'h0, pa});
        rd_chk(`SPO_REG_STATUS, 32'h4, 32'h0, "run after stop");
        chk("both bits high seen", 32'h0, {31'h0, both});
        tally_and_finish;
    end
endmodule
